// ### design/ievt_pkg.sv
// Package for the I2C event interrupt and low-power block
package ievt_pkg;

	localparam int NUM_EVT = 8;

	// Event indices in struct field order; the flag bit is NUM_EVT - 1 - index
	localparam int EVT_HDR   = 0;
	localparam int EVT_BYTE  = 1;
	localparam int EVT_ADDR  = 2;
	localparam int EVT_START = 3;
	localparam int EVT_ACKF  = 4;
	localparam int EVT_STOP  = 5;
	localparam int EVT_ARBITRATION_LOST_FLAG  = 6;
	localparam int EVT_BUS_ERROR_FLAG  = 7;

	// Register offsets (byte addresses)
	localparam logic [3:0] OFS_STATUS = 4'h0;
	localparam logic [3:0] OFS_MASK   = 4'h4;
	localparam logic [3:0] OFS_CTRL   = 4'h8;
	localparam logic [3:0] OFS_STATE  = 4'hC;

	// Control field positions
	localparam int CTRL_IRQ_EN = 0;

	// Reset values
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_MASK  = 8'h00;
	localparam logic       RST_EN    = 1'b0;

	typedef enum logic [1:0] {
		IEVT_RUN  = 2'b00,
		IEVT_WAIT = 2'b01,
		IEVT_HALT = 2'b11
	} ievt_mode_t;

	typedef struct packed {
		logic header_sent_flag;
		logic byte_done_flag;
		logic addr_match_flag;
		logic start_sent_flag;
		logic ack_failure_flag;
		logic stop_seen_flag;
		logic arbitration_lost_flag;
		logic bus_error_flag;
	} ievt_events_t;

endpackage : ievt_pkg

// ### design/ievt_top.sv
// I2C event flags, shared interrupt, wake and low-power gating
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
// Overview of operation
// - WAIT keeps operating; enabled interrupt wakes
// - HALT freezes the flag, mask, enable and read-data registers
// - HALT: bus inactive, no acknowledges driven
// - Resume only after wake from HALT
// - Enabled, unmasked events end WAIT, never HALT
// - Eight event sources, one shared enable
// - Events merged onto one interrupt line
// - Interrupt needs flag and enable; CPU unmasks
// - Summary flag set when any event flag is set, masked or not
// - Hold SCL low for stretching flags
module ievt_top (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic [3:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	input  wire ievt_pkg::ievt_events_t evt_set,
	input  wire logic                  engine_ack_req,
	input  wire logic                  mode_wait,
	input  wire logic                  mode_halt,
	output logic                       irq,
	output logic                       wake_req,
	output logic                       any_event_flag,
	output logic                       scl_hold_low,
	output logic                       ack_drive,
	output logic                       engine_run
);

	ievt_pkg::ievt_mode_t mode_r, mode_nxt;
	logic [7:0]  flags_r, flags_nxt;
	logic [7:0]  mask_r, mask_nxt;
	logic        en_r, en_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic        wait_r, wait_nxt;
	logic        irq_r, irq_nxt;
	logic        wake_r, wake_nxt;
	logic        any_r, any_nxt;
	logic        hold_r, hold_nxt;
	logic        ackd_r, ackd_nxt;
	logic        run_r, run_nxt;
	logic [7:0]  set_vec;
	logic        halted;
	logic        acc;
	logic        wr_go;

	assign set_vec = evt_set;
	assign halted  = (mode_r == ievt_pkg::IEVT_HALT);
	assign acc     = (avs_read | avs_write) & ~wait_r;
	// Writes land only on the edge where waitrequest is seen low
	assign wr_go   = avs_write & wait_r;

	always_comb
	begin
		mode_nxt = mode_r;
		if (mode_halt)
			mode_nxt = ievt_pkg::IEVT_HALT;
		else if (mode_wait)
			mode_nxt = ievt_pkg::IEVT_WAIT;
		else
			mode_nxt = ievt_pkg::IEVT_RUN;
	end

	always_comb
	begin
		flags_nxt = flags_r;
		mask_nxt  = mask_r;
		en_nxt    = en_r;
		rdata_nxt = rdata_r;
		wait_nxt  = 1'b0;
		if (!halted)
		begin
			// Write-one-to-clear first, so a coincident event survives
			if (wr_go && avs_address == ievt_pkg::OFS_STATUS)
				flags_nxt = flags_r & ~avs_writedata[7:0];
			flags_nxt = flags_nxt | set_vec;
			if (wr_go && avs_address == ievt_pkg::OFS_MASK)
				mask_nxt = avs_writedata[7:0];
			if (wr_go && avs_address == ievt_pkg::OFS_CTRL)
				en_nxt = avs_writedata[ievt_pkg::CTRL_IRQ_EN];
			if (acc && avs_read)
			begin
				unique case (avs_address)
					ievt_pkg::OFS_STATUS: rdata_nxt = {24'h000000, flags_r};
					ievt_pkg::OFS_MASK:   rdata_nxt = {24'h000000, mask_r};
					ievt_pkg::OFS_CTRL:   rdata_nxt = {31'h0, en_r};
					ievt_pkg::OFS_STATE:  rdata_nxt = {29'h0, halted,
						mode_r == ievt_pkg::IEVT_WAIT, any_r};
					default:              rdata_nxt = 32'h00000000;
				endcase
			end
			// One wait state: answer on the second edge of a request
			wait_nxt = acc;
		end
	end

	always_comb
	begin
		logic pend;
		pend     = |(flags_r & ~mask_r);
		any_nxt  = |flags_r;
		irq_nxt  = en_r & pend;
		// Wake reaches the power controller only outside HALT
		wake_nxt = en_r & pend & ~halted;
		// Struct order puts the first field on the top bit, so indices run reversed
		hold_nxt = ~halted & (flags_r[ievt_pkg::NUM_EVT - 1 - ievt_pkg::EVT_HDR] |
			flags_r[ievt_pkg::NUM_EVT - 1 - ievt_pkg::EVT_BYTE] |
			flags_r[ievt_pkg::NUM_EVT - 1 - ievt_pkg::EVT_ADDR] |
			flags_r[ievt_pkg::NUM_EVT - 1 - ievt_pkg::EVT_START]);
		ackd_nxt = engine_ack_req & ~halted & ~mode_halt;
		run_nxt  = ~mode_halt;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			mode_r  <= ievt_pkg::IEVT_RUN;
			flags_r <= ievt_pkg::RST_FLAGS;
			mask_r  <= ievt_pkg::RST_MASK;
			en_r    <= ievt_pkg::RST_EN;
			rdata_r <= 32'h00000000;
			wait_r  <= 1'b0;
			irq_r   <= 1'b0;
			wake_r  <= 1'b0;
			any_r   <= 1'b0;
			hold_r  <= 1'b0;
			ackd_r  <= 1'b0;
			run_r   <= 1'b1;
		end
		else
		begin
			mode_r  <= mode_nxt;
			flags_r <= flags_nxt;
			mask_r  <= mask_nxt;
			en_r    <= en_nxt;
			rdata_r <= rdata_nxt;
			wait_r  <= wait_nxt;
			irq_r   <= irq_nxt;
			wake_r  <= wake_nxt;
			any_r   <= any_nxt;
			hold_r  <= hold_nxt;
			ackd_r  <= ackd_nxt;
			run_r   <= run_nxt;
		end
	end

	assign avs_readdata    = rdata_r;
	// Requests stall while halted, since the slave is frozen too
	assign avs_waitrequest = ~wait_r;
	assign irq             = irq_r;
	assign wake_req        = wake_r;
	assign any_event_flag  = any_r;
	assign scl_hold_low    = hold_r;
	assign ack_drive       = ackd_r;
	assign engine_run      = run_r;

	property p_halt_freeze;
		@(posedge sys_clk) disable iff (rst)
		halted |=> (flags_r == $past(flags_r) && mask_r == $past(mask_r));
	endproperty
	a_halt_freeze: assert property (p_halt_freeze) else $error("registers moved in halt");

	property p_no_ack_halt;
		@(posedge sys_clk) disable iff (rst)
		mode_halt |=> !ack_drive;
	endproperty
	a_no_ack_halt: assert property (p_no_ack_halt) else $error("ack driven in halt");

	property p_no_wake_halt;
		@(posedge sys_clk) disable iff (rst)
		halted |=> !wake_req;
	endproperty
	a_no_wake_halt: assert property (p_no_wake_halt) else $error("event woke from halt");

	property p_irq_cause;
		@(posedge sys_clk) disable iff (rst)
		irq |-> $past(en_r) && $past(|(flags_r & ~mask_r));
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");

	property p_irq_rise;
		@(posedge sys_clk) disable iff (rst)
		(en_r && |(flags_r & ~mask_r)) |=> irq;
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq late");

	property p_any;
		@(posedge sys_clk) disable iff (rst)
		(|flags_r) |=> any_event_flag;
	endproperty
	a_any: assert property (p_any) else $error("summary flag missing");

	property p_hold;
		@(posedge sys_clk) disable iff (rst)
		(!halted && flags_r[ievt_pkg::NUM_EVT - 1 - ievt_pkg::EVT_BYTE]) |=> scl_hold_low;
	endproperty
	a_hold: assert property (p_hold) else $error("scl not held");

	property p_hold_cause;
		@(posedge sys_clk) disable iff (rst)
		scl_hold_low |-> $past(|(flags_r & 8'hF0));
	endproperty
	a_hold_cause: assert property (p_hold_cause) else $error("scl held without cause");

	property p_hold_halt;
		@(posedge sys_clk) disable iff (rst)
		halted |=> !scl_hold_low;
	endproperty
	a_hold_halt: assert property (p_hold_halt) else $error("scl held in halt");

	property p_run_halt;
		@(posedge sys_clk) disable iff (rst)
		mode_halt |=> !engine_run;
	endproperty
	a_run_halt: assert property (p_run_halt) else $error("engine runs in halt");

	property p_wake_irq;
		@(posedge sys_clk) disable iff (rst)
		wake_req |-> irq;
	endproperty
	a_wake_irq: assert property (p_wake_irq) else $error("wake without interrupt");

	property p_irq_off;
		@(posedge sys_clk) disable iff (rst)
		!en_r |=> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

	property p_any_off;
		@(posedge sys_clk) disable iff (rst)
		(flags_r == 8'h00) |=> !any_event_flag;
	endproperty
	a_any_off: assert property (p_any_off) else $error("summary flag stuck");

	property p_wait_pulse;
		@(posedge sys_clk) disable iff (rst)
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");

	property p_halt_stall;
		@(posedge sys_clk) disable iff (rst)
		(halted && $past(halted)) |-> avs_waitrequest;
	endproperty
	a_halt_stall: assert property (p_halt_stall) else $error("bus answered in halt");

	// Per-bit checks of the sticky status: set wins, write-one clears
	for (genvar g = 0; g < ievt_pkg::NUM_EVT; g++)
	begin : g_bit
		property p_bit_set;
			@(posedge sys_clk) disable iff (rst)
			(!halted && set_vec[g]) |=> flags_r[g];
		endproperty
		a_bit_set: assert property (p_bit_set) else $error("status bit not set");

		property p_bit_clr;
			@(posedge sys_clk) disable iff (rst)
			(!halted && wr_go && avs_address == ievt_pkg::OFS_STATUS && avs_writedata[g]
				&& !set_vec[g]) |=> !flags_r[g];
		endproperty
		a_bit_clr: assert property (p_bit_clr) else $error("status bit not cleared");
	end

	property p_event_set;
		@(posedge sys_clk) disable iff (rst)
		(!halted && |set_vec) |=> ((flags_r & $past(set_vec)) == $past(set_vec));
	endproperty
	a_event_set: assert property (p_event_set) else $error("event lost");

	property p_wait_wake;
		@(posedge sys_clk) disable iff (rst)
		(mode_r == ievt_pkg::IEVT_WAIT && en_r && |(flags_r & ~mask_r)) |=> wake_req;
	endproperty
	a_wait_wake: assert property (p_wait_wake) else $error("no wake from wait");

	property p_resume;
		@(posedge sys_clk) disable iff (rst)
		(halted && !mode_halt) |=> ##1 engine_run;
	endproperty
	a_resume: assert property (p_resume) else $error("no resume");

endmodule : ievt_top

// ### test/ievt_partner.sv
// Model of the CPU power controller that faces the event block
`timescale 1ns/1ps
module ievt_partner (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic wake_req,
	input  wire logic go_wait,
	input  wire logic go_halt,
	input  wire logic ext_wake,
	output logic      mode_wait,
	output logic      mode_halt
);
	always_ff @(posedge sys_clk)
	begin
		if (rst || (mode_wait && wake_req))
			mode_wait <= 1'b0;
		else if (go_wait)
			mode_wait <= 1'b1;
		// Only an outside source ends halt; the block's own request must not
		if (rst || ext_wake)
			mode_halt <= 1'b0;
		else if (go_halt)
			mode_halt <= 1'b1;
	end
endmodule : ievt_partner

// ### test/test_ievt_top.sv
// Self-checking bench for the event interrupt block
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
	$display("MISMATCH %0t %h %h", $time, a, e); end end
module test_ievt_top;
	logic                   sys_clk = 0, rst = 1, rd = 0, wr = 0, ack = 0;
	logic                   gw = 0, gh = 0, xw = 0;
	logic [3:0]             adr = 0;
	logic [31:0]            wd = 0, rdat, q;
	logic                   waitr, irq, wake, anyf, hold, ackd, run, mw, mh;
	ievt_pkg::ievt_events_t ev_set = '0;
	int                     bad_count = 0, tests_run = 0, cyc = 0;
	always #5 sys_clk = ~sys_clk;
	ievt_top ievt_top_inst (.sys_clk(sys_clk), .rst(rst), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
		.avs_waitrequest(waitr), .evt_set(ev_set), .engine_ack_req(ack),
		.mode_wait(mw), .mode_halt(mh), .irq(irq), .wake_req(wake),
		.any_event_flag(anyf), .scl_hold_low(hold), .ack_drive(ackd), .engine_run(run));
	ievt_partner ievt_partner_inst (.sys_clk(sys_clk), .rst(rst), .wake_req(wake),
		.go_wait(gw), .go_halt(gh), .ext_wake(xw), .mode_wait(mw), .mode_halt(mh));
	task automatic stop_test;
		if (bad_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	// Generous ceiling: the whole sequence needs well under a thousand cycles
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			bad_count++;
			stop_test();
		end
	end
	task automatic settle;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask : settle
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		do @(posedge sys_clk); while (waitr !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic pulse(input logic [7:0] b);
		@(posedge sys_clk);
		ev_set <= b;
		@(posedge sys_clk);
		ev_set <= '0;
		settle();
	endtask : pulse
	task automatic t_events;
		logic [7:0] b;
		for (int i = 0; i < 8; i++)
		begin
			b = 8'h01 << i;
			bus(1'b1, ievt_pkg::OFS_CTRL, 32'h0);
			pulse(b);
			`CHK(irq, 1'b0)
			`CHK(anyf, 1'b1)
			`CHK(hold, i >= 4)
			bus(1'b0, ievt_pkg::OFS_STATUS, 32'h0);
			`CHK(q[7:0], b)
			bus(1'b1, ievt_pkg::OFS_CTRL, 32'h1);
			settle();
			`CHK(irq, 1'b1)
			bus(1'b1, ievt_pkg::OFS_MASK, {24'h0, b});
			settle();
			`CHK(irq, 1'b0)
			bus(1'b1, ievt_pkg::OFS_MASK, 32'h0);
			bus(1'b1, ievt_pkg::OFS_STATUS, {24'h0, b});
			settle();
			`CHK(anyf, 1'b0)
			`CHK(irq, 1'b0)
		end
	endtask : t_events
	task automatic t_wait;
		@(posedge sys_clk);
		gw <= 1'b1;
		@(posedge sys_clk);
		gw <= 1'b0;
		settle();
		`CHK(mw, 1'b1)
		pulse(8'h01);
		`CHK(mw, 1'b0)
		`CHK(run, 1'b1)
		bus(1'b1, ievt_pkg::OFS_STATUS, 32'hFF);
	endtask : t_wait
	task automatic t_halt;
		@(posedge sys_clk);
		ack <= 1'b1;
		settle();
		`CHK(ackd, 1'b1)
		@(posedge sys_clk);
		gh <= 1'b1;
		@(posedge sys_clk);
		gh <= 1'b0;
		settle();
		`CHK(run, 1'b0)
		`CHK(ackd, 1'b0)
		pulse(8'h80);
		`CHK(wake, 1'b0)
		`CHK(mh, 1'b1)
		@(posedge sys_clk);
		xw <= 1'b1;
		@(posedge sys_clk);
		xw <= 1'b0;
		ack <= 1'b0;
		settle();
		`CHK(run, 1'b1)
		bus(1'b0, ievt_pkg::OFS_STATUS, 32'h0);
		`CHK(q[7:0], 8'h00)
	endtask : t_halt
	initial
	begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		settle();
		`CHK(run, 1'b1)
		`CHK(irq, 1'b0)
		bus(1'b0, 4'h2, 32'h0);
		`CHK(q, 32'h0)
		t_events();
		t_wait();
		t_halt();
		stop_test();
	end
endmodule : test_ievt_top
